/* File: logic/lbm_map.vh */
// register offsets, field layouts, reset values for the leaky bucket activity monitor
// assumes a 32-bit apb slave with one register per aligned word
`ifndef LBM_MAP_VH
`define LBM_MAP_VH
`define LBM_ADDR_W       8
`define LBM_OFF_SIZE     8'h00
`define LBM_OFF_LEAK     8'h04
`define LBM_OFF_UPPER    8'h08
`define LBM_OFF_LOWER    8'h0C
`define LBM_OFF_LEVEL    8'h10
`define LBM_OFF_STAT     8'h14
`define LBM_OFF_CLR      8'h18
`define LBM_OFF_IEN      8'h1C
`define LBM_RST_SIZE     8'h08
`define LBM_RST_LEAK     8'h01
`define LBM_RST_UPPER    8'h06
`define LBM_RST_LOWER    8'h04
`define LBM_LEAK_W       2
`define LBM_ST_RAISE     0
`define LBM_ST_CLEAR     1
`define LBM_ST_W         2
`endif

/* File: logic/lbm_leak_timer.v */
// leak timer: counts clean cycles and pulses when the programmed run is complete
// assumes cycle strobes from the same clock domain
`timescale 1ns/100ps
module lbm_leak_timer
(
	input  wire       ref_clk,
	input  wire       rst_n,
	input  wire       clkEn,
	input  wire       cycleTick,
	input  wire       faulty,
	input  wire [1:0] leakSel,
	output wire       leakPulse
);
	reg  [2:0] runCnt_r;
	wire [2:0] runLast;

	assign runLast   = {leakSel[1] & leakSel[0], leakSel[1], leakSel[1] | leakSel[0]};
	assign leakPulse = cycleTick & ~faulty & (runCnt_r >= runLast);

	always @(posedge ref_clk)
	begin
		if (!rst_n)
			runCnt_r <= 3'h0;
		else if (clkEn && cycleTick)
		begin
			if (faulty || leakPulse)
				runCnt_r <= 3'h0;
			else
				runCnt_r <= runCnt_r + 3'h1;
		end
	end
endmodule

/* File: logic/lbm_activity_monitor.v */
// leaky bucket activity monitor with apb registers and interrupt
// assumes cycle tick and fault verdict come from logic on ref_clk
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "lbm_map.vh"

// What this block does
// - each faulty monitoring cycle adds one to the bucket.
// - each run of 1, 2, 4 or 8 clean cycles, chosen by the leak setting, takes one from the bucket.
// - the bucket never rises above the programmed maximum size.
// - the maximum size register is eight bits read/write resetting to 0x08.
// - the leak rate register is read/write resetting to 0x01.
// - reaching the lower threshold clears the alarm raised at the upper threshold.
module lbm_activity_monitor
(
	input  wire        ref_clk,
	input  wire        rst_n,
	input  wire        clkEn,
	input  wire        cycleTick,
	input  wire        inputFaulty,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire        pslverr,
	output reg  [31:0] prdata,
	output wire        alarm,
	output wire        irq
);
	// ************************************************************
	// registers
	// ************************************************************
	reg  [7:0]  sizeCfg_r;
	reg  [7:0]  leakCfg_r;
	reg  [7:0]  upperCfg_r;
	reg  [7:0]  lowerCfg_r;
	reg  [7:0]  bucket_r;
	reg  [7:0]  bucket_nxt;
	reg         alarm_r;
	reg         alarm_nxt;
	reg  [1:0]  status_r;
	reg  [1:0]  ien_r;
	reg  [31:0] rdMux;
	reg         hit;
	wire        selSize;
	wire        selLeak;
	wire        selUpper;
	wire        selLower;
	wire        selLevel;
	wire        selStat;
	wire        selClr;
	wire        selIen;
	wire        setupPhase;
	wire        wrEn;
	wire        leakPulse;
	wire [1:0]  leakSel;
	wire [1:0]  evt;
	wire [1:0]  clrMask;
	wire [1:0]  statusNxt;
	wire [1:0]  irqBit;

	// ************************************************************
	// apb access
	// ************************************************************
	assign selSize    = (paddr == `LBM_OFF_SIZE);
	assign selLeak    = (paddr == `LBM_OFF_LEAK);
	assign selUpper   = (paddr == `LBM_OFF_UPPER);
	assign selLower   = (paddr == `LBM_OFF_LOWER);
	assign selLevel   = (paddr == `LBM_OFF_LEVEL);
	assign selStat    = (paddr == `LBM_OFF_STAT);
	assign selClr     = (paddr == `LBM_OFF_CLR);
	assign selIen     = (paddr == `LBM_OFF_IEN);
	assign setupPhase = psel & ~penable;
	assign pready     = 1'b1;
	assign pslverr    = psel & penable & ~hit;
	assign wrEn       = psel & penable & pwrite & clkEn;

	always @*
	begin
		hit   = 1'b1;
		rdMux = 32'h0;
		if (selSize)
			rdMux = {24'h0, sizeCfg_r};
		else if (selLeak)
			rdMux = {24'h0, leakCfg_r};
		else if (selUpper)
			rdMux = {24'h0, upperCfg_r};
		else if (selLower)
			rdMux = {24'h0, lowerCfg_r};
		else if (selLevel)
			rdMux = {23'h0, alarm_r, bucket_r};
		else if (selStat)
			rdMux = {30'h0, status_r};
		else if (selIen)
			rdMux = {30'h0, ien_r};
		else if (!selClr)
			hit = 1'b0;
	end

	// ************************************************************
	// read data
	// ************************************************************
	always @(posedge ref_clk)
	begin
		if (!rst_n)
			prdata <= 32'h0;
		else if (clkEn && setupPhase && !pwrite)
			prdata <= rdMux;
	end

	// ************************************************************
	// configuration registers
	// ************************************************************

	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			sizeCfg_r  <= `LBM_RST_SIZE;
			leakCfg_r  <= `LBM_RST_LEAK;
			upperCfg_r <= `LBM_RST_UPPER;
			lowerCfg_r <= `LBM_RST_LOWER;
			ien_r      <= 2'h0;
		end
		else if (wrEn)
		begin
			case (paddr)
				`LBM_OFF_SIZE:  sizeCfg_r  <= pwdata[7:0];
				`LBM_OFF_LEAK:  leakCfg_r  <= pwdata[7:0];
				`LBM_OFF_UPPER: upperCfg_r <= pwdata[7:0];
				`LBM_OFF_LOWER: lowerCfg_r <= pwdata[7:0];
				`LBM_OFF_IEN:   ien_r      <= pwdata[1:0];
				default:        ien_r      <= ien_r;
			endcase
		end
	end

	// ************************************************************
	// bucket
	// ************************************************************
	assign leakSel = leakCfg_r[`LBM_LEAK_W-1:0];

	lbm_leak_timer uLeak
	(
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.clkEn     (clkEn),
		.cycleTick (cycleTick),
		.faulty    (inputFaulty),
		.leakSel   (leakSel),
		.leakPulse (leakPulse)
	);

	always @*
	begin
		bucket_nxt = bucket_r;
		if (cycleTick && inputFaulty)
		begin
			if (bucket_r < sizeCfg_r)
				bucket_nxt = bucket_r + 8'h01;
			else
				bucket_nxt = sizeCfg_r;
		end
		else if (leakPulse && bucket_r != 8'h00)
			bucket_nxt = bucket_r - 8'h01;
	end

	always @(posedge ref_clk)
	begin
		if (!rst_n)
			bucket_r <= 8'h00;
		else if (clkEn)
			bucket_r <= bucket_nxt;
	end

	// ************************************************************
	// alarm
	// ************************************************************
	always @*
	begin
		alarm_nxt = alarm_r;
		if (cycleTick)
		begin
			if (bucket_nxt >= upperCfg_r)
				alarm_nxt = 1'b1;
			else if (bucket_nxt <= lowerCfg_r)
				alarm_nxt = 1'b0;
		end
	end

	always @(posedge ref_clk)
	begin
		if (!rst_n)
			alarm_r <= 1'b0;
		else if (clkEn)
			alarm_r <= alarm_nxt;
	end

	// ************************************************************
	// status and interrupt
	// ************************************************************
	assign evt     = {alarm_r & ~alarm_nxt, ~alarm_r & alarm_nxt};
	assign clrMask = (wrEn && selClr) ? pwdata[1:0] : 2'h0;

	genvar gi;
	generate
		for (gi = 0; gi < `LBM_ST_W; gi = gi + 1)
		begin : gStat
			assign statusNxt[gi] = evt[gi] | (status_r[gi] & ~clrMask[gi]);
			assign irqBit[gi]    = status_r[gi] & ien_r[gi];
		end
	endgenerate

	always @(posedge ref_clk)
	begin
		if (!rst_n)
			status_r <= 2'h0;
		else if (clkEn)
			status_r <= statusNxt;
	end

	assign alarm = alarm_r;
	assign irq   = |irqBit;
endmodule

/* File: testbench/lbm_activity_monitor_properties.sv */
// checker: port properties of the monitor
// assumes a bind into the monitor top
`timescale 1ns/100ps
module lbm_activity_monitor_properties
(
	input wire		ref_clk,
	input wire		rst_n,
	input wire		clkEn,
	input wire		cycleTick,
	input wire		psel,
	input wire		penable,
	input wire		pwrite,
	input wire [7:0]	paddr,
	input wire		pslverr,
	input wire		alarm,
	input wire		irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_bad_addr: assert property (psel && penable && paddr > 8'h1C |-> pslverr) else $error("addr");
	a_alarm_rise: assert property ($rose(alarm) |-> $past(cycleTick && clkEn)) else $error("rise");
	a_alarm_fall: assert property ($fell(alarm) && $past(rst_n) |-> $past(cycleTick && clkEn)) else $error("fall");
	a_irq_cause: assert property ($rose(irq) |-> $past(cycleTick || psel && pwrite)) else $error("irq");
	a_reset_quiet: assert property ($rose(rst_n) |-> !alarm && !irq) else $error("reset");
	a_err_mapped: assert property (psel && penable && paddr <= 8'h1C && paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped");
	a_freeze_state: assert property (!clkEn |=> $stable(alarm) && $stable(irq)) else $error("freeze");
	cover property ($rose(irq));
	cover property ($rose(alarm));
	cover property ($fell(alarm));
	cover property (pslverr);
endmodule
bind lbm_activity_monitor lbm_activity_monitor_properties i_chk (.ref_clk, .rst_n, .clkEn, .cycleTick, .psel,
	.penable, .pwrite, .paddr, .pslverr, .alarm, .irq);

/* File: testbench/lbm_activity_monitor_test.sv */
// bench: apb and monitor stimulus with checks
// assumes the design sources on the include path
`timescale 1ns/100ps
module lbm_activity_monitor_test;
	reg		ref_clk = 0, rst_n = 0, clkEn = 1, cycleTick = 0, inputFaulty = 0, psel = 0, penable = 0, pwrite = 0;
	reg [7:0]	paddr = 0;
	reg [31:0]	pwdata = 0;
	wire		pready, pslverr, alarm, irq;
	wire [31:0]	prdata;
	integer		bad_count = 0, cmp_count = 0;
	reg		lastErr = 0;
	always #2.5 ref_clk = ~ref_clk;
	lbm_activity_monitor i_dut (.ref_clk, .rst_n, .clkEn, .cycleTick, .inputFaulty, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pready, .pslverr, .prdata, .alarm, .irq);
	task chk(input [31:0] g, e);
		cmp_count++;
		if (g !== e) $display("[FAIL] %0t got %h", $time, g);
		if (g !== e) bad_count++;
	endtask
	task acc(input w, input [7:0] a, input [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk) penable <= 1'h1;
		do @(posedge ref_clk); while (pready !== 1'h1);
		lastErr = pslverr;
		if (!w) chk(prdata, d);
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge ref_clk);
	endtask
	task tick(input f, input integer n);
		repeat (n)
		begin
			cycleTick <= 1'h1;
			inputFaulty <= f;
			@(posedge ref_clk) cycleTick <= 1'h0;
			@(posedge ref_clk);
		end
	endtask
	task results(input integer extra);
		bad_count = bad_count + extra;
		$display("bad_count %0d cmp_count %0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial #9000 results(1);
	initial
	begin
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'h1;
		@(posedge ref_clk);
		acc(1'h0, 8'h00, 32'h08);
		chk(lastErr, 32'h0);
		acc(1'h0, 8'h04, 32'h01);
		tick(1'h1, 10);
		chk(alarm, 32'h1);
		acc(1'h0, 8'h10, 32'h108);
		tick(1'h0, 1);
		acc(1'h0, 8'h10, 32'h108);
		tick(1'h0, 7);
		acc(1'h0, 8'h10, 32'h004);
		acc(1'h0, 8'h14, 32'h003);
		acc(1'h1, 8'h00, 32'hFFFF_FF02);
		acc(1'h0, 8'h00, 32'h02);
		tick(1'h1, 1);
		acc(1'h0, 8'h10, 32'h002);
		clkEn <= 1'h0;
		tick(1'h0, 2);
		acc(1'h1, 8'h04, 32'h00);
		clkEn <= 1'h1;
		acc(1'h0, 8'h04, 32'h01);
		acc(1'h0, 8'h10, 32'h002);
		acc(1'h1, 8'h04, 32'h00);
		tick(1'h0, 1);
		acc(1'h0, 8'h10, 32'h001);
		acc(1'h1, 8'h1C, 32'h03);
		chk(irq, 32'h1);
		acc(1'h1, 8'h18, 32'h03);
		chk(irq, 32'h0);
		acc(1'h0, 8'h40, 32'h00);
		chk(lastErr, 32'h1);
		results(0);
	end
endmodule
